/* inc/hbb_pkg.sv */
// Purpose: shared constants and types of the host bus buffer port
// Assumes: 50 MHz mclk, synchronous active high srst
// Notes: times are kept in ns and turned into cycle counts here
// Behaviour
// - Host address is twenty bits, bit 0 least significant, decoded for memory and I/O.
// - I/O read strobe reads internal registers, I/O write strobe loads them.
// - Memory read at a decoded buffer address returns the addressed buffer byte.
// - Memory write stores the byte, or loads it as microcode when download and external microcode mode are both enabled.
// - All four host strobes are ignored while the DMA address enable is high.
// - Ready stays tri-stated during every I/O register transfer.
// - Each memory access pulls ready low for 220 to 460 ns.
// - Edge interrupt goes low 100 to 250 ns, then tri-state.
// - Level interrupt held low until acknowledged, tri-stated when inactive.
// - Hardware reset initialises all logic and holds microcontroller program counter at zero.
// - External data buffer enable is low during any register or buffer access.
// - Eight-bit host data bus driven only during host reads.
// - Thirteen-bit RAM address bus addresses the external static RAM.
// - Sixteen-bit tri-state RAM data bus links RAM, device and host.
// - RAM write strobe for every buffer write; separate RAM read strobe.
// - Separate active low chip selects enable first and second RAM.
// - Display mode splits buffer into 4K display and 4K attribute storage.
// - Printer mode uses 4K or 8K buffer and interrupts on begin-operation.
// - Distributed function mode uses 8K buffer plus 128 communication bytes.
// - Host buffer RAM address equals low 13 host address bits.
// - Microcontroller wins RAM arbitration for up to HOST_WAIT wait cycles; host is delayed through ready, then takes the RAM.
package hbb_pkg;
   // Operating modes
   typedef enum logic [1:0] {
      HBB_DISPLAY,
      HBB_PRINTER,
      HBB_DISTRIB
   } hbb_mode_t;

   // Address decode
   localparam logic [19:0] MEM_BASE     = 20'hc8000;
   localparam logic [19:0] IO_BASE      = 20'h00220;
   localparam logic [3:0]  OFF_OPER     = 4'h8;
   localparam logic [3:0]  OFF_ACK      = 4'h9;
   localparam logic [3:0]  OFF_STAT     = 4'ha;
   localparam logic [13:0] LIM_4K       = 14'h1000;
   localparam logic [13:0] LIM_8K       = 14'h2000;
   localparam logic [13:0] LIM_COMM     = 14'h2080;
   localparam logic [7:0]  UNMAPPED     = 8'hff;

   // Operation register fields and reset value
   localparam int          OP_SOFT_RST  = 0;
   localparam int          OP_EXT_MODE  = 1;
   localparam int          OP_DOWNLOAD  = 2;
   localparam int          OP_PC_RST    = 4;
   localparam logic [7:0]  OP_RST       = 8'h00;

   // Timing
   localparam int          CLK_NS       = 20;
   localparam int          RDY_MIN_NS   = 220;
   localparam int          RDY_MAX_NS   = 460;
   localparam int          RAM_ACC_NS   = 120;
   localparam int          EIRQ_MIN_NS  = 100;
   localparam int          EIRQ_MAX_NS  = 250;
   localparam int          RDY_MIN_CYC  = (RDY_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int          RDY_MAX_CYC  = RDY_MAX_NS / CLK_NS;
   localparam int          RAM_CYC      = (RAM_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int          EIRQ_MIN_CYC = (EIRQ_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int          EIRQ_MAX_CYC = EIRQ_MAX_NS / CLK_NS;
   localparam logic [4:0]  READY_LO_CYC = 5'(RDY_MIN_CYC + 1);
   localparam logic [4:0]  RAM_LAST     = 5'(RAM_CYC - 1);
   localparam logic [4:0]  HOST_WAIT    = 5'(RDY_MAX_CYC - RAM_CYC - 4);
   localparam logic [3:0]  EIRQ_CYC     = 4'(EIRQ_MIN_CYC + 1);
endpackage

/* hdl/hbb_pulse.sv */
// Purpose: low pulse of fixed length on a tri-state edge interrupt pin
// Assumes: fire is a one-cycle pulse
// Notes: a new fire during a pulse restarts the count
`timescale 1ns/1ps
module hbb_pulse import hbb_pkg::*; (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic fire,
   output logic      pulse_out,
   output logic      pulse_oe
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       oe;
   } hbb_pst_t;

   hbb_pst_t s;
   hbb_pst_t n;

   // Countdown of the low time
   always_comb begin
      n = s;
      if (fire) begin
         n.cnt = EIRQ_CYC;
         n.oe  = 1'b1;
      end else if (s.cnt > 4'h1) begin
         n.cnt = s.cnt - 4'h1;
      end else begin
         n.cnt = 4'h0;
         n.oe  = 1'b0;
      end
      if (srst) begin
         n = '0;
      end
   end

   always_ff @(posedge mclk) begin
      s <= n;
   end

   assign pulse_out = 1'b0;
   assign pulse_oe  = s.oe;
endmodule

/* hdl/hbb_port.sv */
// Purpose: host bus slave to buffer RAM, operation register and interrupts
// Assumes: host pins synchronous to mclk, address stable during a strobe
// Notes: microcontroller holds uc_req until it sees uc_grant for its access
`timescale 1ns/1ps
module hbb_port import hbb_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic [19:0] host_addr,
   input  wire logic        io_read_strobe_n,
   input  wire logic        io_write_strobe_n,
   input  wire logic        mem_read_strobe_n,
   input  wire logic        mem_write_strobe_n,
   input  wire logic        dma_addr_enable,
   input  wire logic [7:0]  host_data_in,
   output logic      [7:0]  host_data_out,
   output logic             host_data_oe,
   output logic             ready_out,
   output logic             ready_oe,
   output logic             edge_irq_out,
   output logic             edge_irq_oe,
   output logic             level_interrupt_n_out,
   output logic             level_interrupt_oe,
   output logic             ext_buffer_enable_n,
   output logic      [12:0] ram_addr,
   input  wire logic [15:0] ram_data_in,
   output logic      [15:0] ram_data_out,
   output logic             ram_data_oe,
   output logic             ram_write_n,
   output logic             ram_read_n,
   output logic             ram_select_first_n,
   output logic             ram_select_second_n,
   input  wire hbb_mode_t   op_mode,
   input  wire logic        printer_buffer_8k,
   input  wire logic        start_op_cmd,
   input  wire logic        uc_irq_req,
   input  wire logic        uc_req,
   input  wire logic        uc_write,
   input  wire logic [13:0] uc_addr,
   input  wire logic [7:0]  uc_wdata,
   output logic             uc_grant,
   output logic      [7:0]  uc_rdata,
   output logic             uc_pc_reset,
   output logic             ext_ucode_mode,
   output logic             ucode_load,
   output logic      [12:0] ucode_addr,
   output logic      [7:0]  ucode_byte
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_IO,
      ST_WAIT,
      ST_RAM,
      ST_HOLD,
      ST_DONE
   } hbb_state_t;

   typedef struct packed {
      hbb_state_t  st;
      logic [4:0]  cnt;
      logic [4:0]  sub;
      logic        is_rd;
      logic        in_range;
      logic        ucode;
      logic [7:0]  rd_data;
      logic        data_oe;
      logic        rdy_oe;
      logic        buf_en_n;
      logic [12:0] ram_addr;
      logic [15:0] ram_wdata;
      logic        ram_doe;
      logic        ram_wr_n;
      logic        ram_rd_n;
      logic        cs1_n;
      logic        cs2_n;
      logic [7:0]  oper;
      logic        lvl_irq;
      logic        fire;
      logic        grant;
      logic [7:0]  uc_rdata;
      logic        ucode_ld;
      logic [12:0] ucode_addr;
      logic [7:0]  ucode_byte;
      logic        pc_rst;
   } hbb_st_t;

   hbb_st_t s;
   hbb_st_t n;

   logic    en;
   logic    io_rd;
   logic    io_wr;
   logic    mem_rd;
   logic    mem_wr;
   logic    ack;

   // Memory window hit
   function automatic logic mem_hit(input logic [19:0] a);
      mem_hit = (a[19:14] == MEM_BASE[19:14]);
   endfunction

   // I/O block hit
   function automatic logic io_hit(input logic [19:0] a);
      io_hit = (a[19:4] == IO_BASE[19:4]);
   endfunction

   // Buffer region allowed by the mode
   function automatic logic region_ok(input hbb_mode_t m, input logic p8k,
                                      input logic [13:0] off);
      case (m)
         HBB_DISPLAY: region_ok = (off < LIM_8K);
         HBB_PRINTER: region_ok = (off < (p8k ? LIM_8K : LIM_4K));
         default:     region_ok = (off < LIM_COMM);
      endcase
   endfunction

   // Byte lane of the selected RAM chip
   function automatic logic [7:0] lane(input logic hi, input logic [15:0] d);
      lane = hi ? d[15:8] : d[7:0];
   endfunction

   // Qualified host strobes
   assign en     = ~dma_addr_enable;
   assign io_rd  = en & ~io_read_strobe_n & io_hit(host_addr);
   assign io_wr  = en & ~io_write_strobe_n & io_hit(host_addr);
   assign mem_rd = en & ~mem_read_strobe_n & mem_hit(host_addr);
   assign mem_wr = en & ~mem_write_strobe_n & mem_hit(host_addr);
   assign ack    = io_wr & (s.st == ST_IDLE) & (host_addr[3:0] == OFF_ACK);

   // Next state of the whole port
   always_comb begin
      n          = s;
      n.fire     = 1'b0;
      n.ucode_ld = 1'b0;
      case (s.st)
         ST_IDLE: begin
            if (io_rd | io_wr) begin
               n.buf_en_n = 1'b0;
               n.st       = ST_IO;
               if (io_rd) begin
                  n.data_oe = 1'b1;
                  if (host_addr[3:0] == OFF_OPER) begin
                     n.rd_data = s.oper;
                  end else if (host_addr[3:0] == OFF_STAT) begin
                     n.rd_data = {5'h00, s.lvl_irq, op_mode};
                  end else begin
                     n.rd_data = UNMAPPED;
                  end
               end else if (host_addr[3:0] == OFF_OPER) begin
                  n.oper = host_data_in;
               end
            end else if (mem_rd | mem_wr) begin
               n.buf_en_n = 1'b0;
               n.rdy_oe   = 1'b1;
               n.is_rd    = mem_rd;
               n.cnt      = 5'h01;
               n.sub      = 5'h00;
               n.in_range = region_ok(op_mode, printer_buffer_8k, host_addr[13:0]);
               n.ucode    = mem_wr & s.oper[OP_DOWNLOAD] & s.oper[OP_EXT_MODE];
               n.st       = ST_WAIT;
            end
         end
         ST_IO: begin
            if (io_read_strobe_n & io_write_strobe_n) begin
               n.data_oe  = 1'b0;
               n.buf_en_n = 1'b1;
               n.st       = ST_IDLE;
            end
         end
         ST_WAIT: begin
            n.cnt = s.cnt + 5'h01;
            if (~uc_req | (s.sub == HOST_WAIT)) begin
               n.sub = 5'h00;
               n.st  = ST_RAM;
               if (s.ucode) begin
                  n.ucode_ld   = 1'b1;
                  n.ucode_addr = host_addr[12:0];
                  n.ucode_byte = host_data_in;
               end else if (s.in_range) begin
                  n.ram_addr = host_addr[12:0];
                  n.cs1_n    = host_addr[13];
                  n.cs2_n    = ~host_addr[13];
                  n.ram_rd_n = ~s.is_rd;
                  n.ram_wr_n = s.is_rd;
                  n.ram_doe  = ~s.is_rd;
                  n.ram_wdata = {host_data_in, host_data_in};
               end
            end else begin
               n.sub = s.sub + 5'h01;
            end
         end
         ST_RAM: begin
            n.cnt = s.cnt + 5'h01;
            n.sub = s.sub + 5'h01;
            if (s.sub == RAM_LAST) begin
               n.rd_data  = s.in_range ? lane(host_addr[13], ram_data_in) : UNMAPPED;
               n.data_oe  = s.is_rd;
               n.ram_rd_n = 1'b1;
               n.ram_wr_n = 1'b1;
               n.ram_doe  = 1'b0;
               n.cs1_n    = 1'b1;
               n.cs2_n    = 1'b1;
               n.st       = ST_HOLD;
            end
         end
         ST_HOLD: begin
            n.cnt = s.cnt + 5'h01;
            if (s.cnt >= READY_LO_CYC) begin
               n.rdy_oe = 1'b0;
               n.st     = ST_DONE;
            end
         end
         ST_DONE: begin
            if (mem_read_strobe_n & mem_write_strobe_n) begin
               n.data_oe  = 1'b0;
               n.buf_en_n = 1'b1;
               n.st       = ST_IDLE;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // Microcontroller side of the RAM
      n.grant = uc_req & (n.st != ST_RAM);
      if (s.grant) begin
         n.uc_rdata = lane(uc_addr[13], ram_data_in);
      end
      if (n.grant) begin
         n.ram_addr  = uc_addr[12:0];
         n.cs1_n     = uc_addr[13];
         n.cs2_n     = ~uc_addr[13];
         n.ram_rd_n  = uc_write;
         n.ram_wr_n  = ~uc_write;
         n.ram_doe   = uc_write;
         n.ram_wdata = {uc_wdata, uc_wdata};
      end else if (n.st != ST_RAM || s.ucode || !s.in_range) begin
         n.ram_rd_n = 1'b1;
         n.ram_wr_n = 1'b1;
         n.ram_doe  = 1'b0;
         n.cs1_n    = 1'b1;
         n.cs2_n    = 1'b1;
      end

      // Interrupt sources, set wins over acknowledge
      n.fire    = uc_irq_req | (start_op_cmd & (op_mode != HBB_DISPLAY));
      n.lvl_irq = n.fire | (s.lvl_irq & ~ack);
      n.pc_rst  = n.oper[OP_PC_RST] | n.oper[OP_SOFT_RST];

      // Synchronous reset values
      if (srst) begin
         n          = '0;
         n.st       = ST_IDLE;
         n.oper     = OP_RST;
         n.buf_en_n = 1'b1;
         n.ram_wr_n = 1'b1;
         n.ram_rd_n = 1'b1;
         n.cs1_n    = 1'b1;
         n.cs2_n    = 1'b1;
         n.pc_rst   = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      s <= n;
   end

   // Edge interrupt pulse
   hbb_pulse u_edge (
      .mclk      (mclk),
      .srst      (srst),
      .fire      (s.fire),
      .pulse_out (edge_irq_out),
      .pulse_oe  (edge_irq_oe)
   );

   // Outputs straight from state, ready and level interrupt pin values tied low
   assign host_data_out         = s.rd_data;
   assign host_data_oe          = s.data_oe;
   assign ready_out             = 1'b0;
   assign ready_oe              = s.rdy_oe;
   assign level_interrupt_n_out = 1'b0;
   assign level_interrupt_oe    = s.lvl_irq;
   assign ext_buffer_enable_n   = s.buf_en_n;
   assign ram_addr              = s.ram_addr;
   assign ram_data_out          = s.ram_wdata;
   assign ram_data_oe           = s.ram_doe;
   assign ram_write_n           = s.ram_wr_n;
   assign ram_read_n            = s.ram_rd_n;
   assign ram_select_first_n    = s.cs1_n;
   assign ram_select_second_n   = s.cs2_n;
   assign uc_grant              = s.grant;
   assign uc_rdata              = s.uc_rdata;
   assign uc_pc_reset           = s.pc_rst;
   assign ext_ucode_mode        = s.oper[OP_EXT_MODE];
   assign ucode_load            = s.ucode_ld;
   assign ucode_addr            = s.ucode_addr;
   assign ucode_byte            = s.ucode_byte;

   // Helper count of ready low cycles
   logic [5:0] lo_cnt_ff;
   always_ff @(posedge mclk) begin
      if (srst | ~s.rdy_oe) begin
         lo_cnt_ff <= 6'h00;
      end else begin
         lo_cnt_ff <= lo_cnt_ff + 6'h01;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_edge_low;
      edge_irq_oe [*6];
   endsequence
   sequence s_edge_off;
      ##1 !edge_irq_oe;
   endsequence

   chk_io_tristate: assert property (s.st == ST_IO |-> !ready_oe)
      else $error("ready driven during I/O transfer");
   chk_dma_ignore: assert property (s.st == ST_IDLE && dma_addr_enable |=> s.st == ST_IDLE)
      else $error("strobe taken while DMA owns bus");
   chk_ready_len: assert property ($fell(ready_oe) |-> lo_cnt_ff >= 6'd11 && lo_cnt_ff <= 6'd23)
      else $error("ready low time out of range");
   chk_edge_pulse: assert property ($rose(edge_irq_oe) |-> ##5 s_edge_off)
      else $error("edge interrupt pulse length wrong");
   chk_edge_held: assert property ($rose(edge_irq_oe) && !s.fire |-> s_edge_low)
      else $error("edge interrupt released early");
   chk_level_hold: assert property (level_interrupt_oe && !ack |=> level_interrupt_oe)
      else $error("level interrupt dropped without acknowledge");
   chk_reset_pc: assert property (@(posedge mclk) disable iff (1'b0) srst |=> uc_pc_reset)
      else $error("program counter not held in reset");
   chk_bus_enable: assert property (host_data_oe |-> !ext_buffer_enable_n)
      else $error("data driven with buffer disabled");
   chk_ram_addr: assert property (s.st == ST_RAM && !ram_select_first_n |-> ram_addr == host_addr[12:0])
      else $error("RAM address differs from host address");
   chk_data_ready: assert property ($fell(ready_oe) && s.is_rd |-> $past(host_data_oe))
      else $error("read data not valid before ready");
   chk_ucode_no_wr: assert property (ucode_load |-> ram_write_n)
      else $error("microcode byte also written to RAM");
endmodule

/* testbench/hbb_sram.sv */
// Purpose: two byte-wide static RAMs behind the buffer RAM pins
// Assumes: chip one on the low data lane, chip two on the high lane
// Notes: a lane that is not read shows a value that changes every cycle
`timescale 1ns/1ps
module hbb_sram (
   input  wire logic        mclk,
   input  wire logic [12:0] ram_addr,
   input  wire logic [15:0] ram_data_out,
   input  wire logic        ram_write_n,
   input  wire logic        ram_read_n,
   input  wire logic        ram_select_first_n,
   input  wire logic        ram_select_second_n,
   output logic      [15:0] ram_data_in
);
   logic [7:0]  mem_lo [0:8191];
   logic [7:0]  mem_hi [0:8191];
   logic [15:0] last_q;
   logic        rd_lo;
   logic        rd_hi;

   initial last_q = 16'h0000;

   // Read lanes, released lanes inverted each cycle
   assign rd_lo = !ram_select_first_n && !ram_read_n;
   assign rd_hi = !ram_select_second_n && !ram_read_n;
   assign ram_data_in[7:0]  = rd_lo ? mem_lo[ram_addr] : ~last_q[7:0];
   assign ram_data_in[15:8] = rd_hi ? mem_hi[ram_addr] : ~last_q[15:8];

   // Store on write strobe with chip selected
   always @(posedge mclk) begin
      last_q <= ram_data_in;
      if (!ram_write_n && !ram_select_first_n)
         mem_lo[ram_addr] <= ram_data_out[7:0];
      if (!ram_write_n && !ram_select_second_n)
         mem_hi[ram_addr] <= ram_data_out[15:8];
   end
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench of the host bus buffer port
// Assumes: 50 MHz mclk, inputs changed at rising edges
// Notes: read results are queued by the drivers and checked by a monitor
`timescale 1ns/1ps
module testbench import hbb_pkg::*;;
   logic        mclk, srst, io_read_strobe_n, io_write_strobe_n;
   logic        mem_read_strobe_n, mem_write_strobe_n, dma_addr_enable;
   logic [19:0] host_addr;
   logic [7:0]  host_data_in, host_data_out, uc_rdata, ucode_byte, uc_wdata;
   logic        host_data_oe, ready_out, ready_oe, edge_irq_out, edge_irq_oe;
   logic        level_interrupt_n_out, level_interrupt_oe, ext_buffer_enable_n;
   logic [12:0] ram_addr, ucode_addr;
   logic [15:0] ram_data_in, ram_data_out;
   logic        ram_data_oe, ram_write_n, ram_read_n;
   logic        ram_select_first_n, ram_select_second_n;
   hbb_mode_t   op_mode;
   logic        printer_buffer_8k, start_op_cmd, uc_irq_req, uc_req, uc_write;
   logic [13:0] uc_addr;
   logic        uc_grant, uc_pc_reset, ext_ucode_mode, ucode_load;
   logic [7:0]  rd_q [$];
   logic        oe_q, grant_seen, load_seen;
   logic [7:0]  load_byte;
   logic [12:0] load_addr;
   int          run, last_run, err_total, comparisons, seed;
   // Mode, 8K printer, offset, RAM access expected
   localparam logic [17:0] TBL [8] = '{
      {2'd0, 1'b0, 14'h0000, 1'b1}, {2'd0, 1'b0, 14'h1fff, 1'b1},
      {2'd0, 1'b0, 14'h2000, 1'b0}, {2'd1, 1'b0, 14'h0fff, 1'b1},
      {2'd1, 1'b0, 14'h1000, 1'b0}, {2'd1, 1'b1, 14'h1abc, 1'b1},
      {2'd2, 1'b0, 14'h2080, 1'b0}, {2'd2, 1'b0, 14'h207f, 1'b1}};

   hbb_port hbb_port_i (.*);
   hbb_sram hbb_sram_i (.mclk(mclk), .ram_addr(ram_addr), .ram_data_out(ram_data_out),
      .ram_write_n(ram_write_n), .ram_read_n(ram_read_n), .ram_data_in(ram_data_in),
      .ram_select_first_n(ram_select_first_n), .ram_select_second_n(ram_select_second_n));

   // Clock, 20 ns period
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Register access: strobe, wait for the buffer enable, release
   task automatic io_acc(input logic wr, input logic [3:0] off, input logic [7:0] d,
                         input logic [7:0] exp);
      int n;
      @(posedge mclk);
      host_addr <= IO_BASE | 20'(off);
      host_data_in <= d;
      if (wr) io_write_strobe_n <= 1'b0;
      else begin
         io_read_strobe_n <= 1'b0;
         rd_q.push_back(exp);
      end
      for (n = 0; n < 5 && ext_buffer_enable_n !== 1'b0; n++) @(negedge mclk);
      check(ext_buffer_enable_n, 1'b0, "io buffer enable");
      @(negedge mclk);
      check(ready_oe, 1'b0, "io ready");
      @(posedge mclk);
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      for (n = 0; n < 5 && ext_buffer_enable_n !== 1'b1; n++) @(negedge mclk);
      check(host_data_oe, 1'b0, "io data release");
   endtask

   // Buffer access: count the wait, note RAM address and select
   task automatic mem_acc(input logic wr, input logic [13:0] off, input logic [7:0] d,
                          input logic [7:0] exp, input logic inreg);
      int n;
      logic [14:0] got;
      got = 15'h7fff;
      @(posedge mclk);
      host_addr <= MEM_BASE | 20'(off);
      host_data_in <= d;
      if (wr) mem_write_strobe_n <= 1'b0;
      else begin
         mem_read_strobe_n <= 1'b0;
         rd_q.push_back(exp);
      end
      for (n = 0; n < 5 && ready_oe !== 1'b1; n++) @(negedge mclk);
      for (n = 0; n < 40 && ready_oe === 1'b1; n++) begin
         if (ram_write_n === 1'b0 || ram_read_n === 1'b0)
            got = {ram_select_second_n, ram_select_first_n, ram_addr};
         check(ext_buffer_enable_n, 1'b0, "mem buffer enable");
         @(negedge mclk);
      end
      check(16'(n >= RDY_MIN_CYC && n <= RDY_MAX_CYC), 16'h1, "ready low length");
      if (!wr) check(host_data_oe, 1'b1, "data before ready");
      if (inreg) check(got, {!off[13], off[13], off[12:0]}, "ram addr and select");
      else check(got, 15'h7fff, "no ram access");
      @(posedge mclk);
      mem_read_strobe_n <= 1'b1;
      mem_write_strobe_n <= 1'b1;
      for (n = 0; n < 5 && ext_buffer_enable_n !== 1'b1; n++) @(negedge mclk);
   endtask

   // Interrupt: pulse a source, measure edge pulse, then acknowledge
   task automatic irq(input logic via_start, input logic exp);
      last_run = 0;
      @(posedge mclk);
      if (via_start) start_op_cmd <= 1'b1;
      else uc_irq_req <= 1'b1;
      @(posedge mclk);
      start_op_cmd <= 1'b0;
      uc_irq_req <= 1'b0;
      repeat (12) @(negedge mclk);
      check(16'(last_run >= EIRQ_MIN_CYC && last_run <= EIRQ_MAX_CYC), 16'(exp), "edge");
      check(level_interrupt_oe, exp, "level held");
      if (exp) io_acc(1'b0, OFF_STAT, 8'h00, {5'h00, 1'b1, 2'(op_mode)});
      io_acc(1'b1, OFF_ACK, 8'h00, 8'h00);
      check(level_interrupt_oe, 1'b0, "level acked");
   endtask

   // Read monitor: oldest note against data on rising data enable
   always @(posedge mclk) begin
      oe_q <= host_data_oe;
      if (host_data_oe === 1'b1 && oe_q !== 1'b1) begin
         if (rd_q.size() == 0) check(16'h0, 16'h1, "unexpected read");
         else check(host_data_out, rd_q.pop_front(), "read data");
      end
   end

   // Edge pulse length, grant and microcode load watchers
   always @(posedge mclk) begin
      if (edge_irq_oe === 1'b1) run <= run + 1;
      else if (run != 0) begin
         last_run <= run;
         run <= 0;
      end
      if (uc_grant === 1'b1) grant_seen <= 1'b1;
      if (ucode_load === 1'b1) begin
         load_seen <= 1'b1;
         load_byte <= ucode_byte;
         load_addr <= ucode_addr;
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      end_of_test();
   end

   // Main sequence
   initial begin
      logic [7:0] d;
      {io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n} = 4'hf;
      {dma_addr_enable, printer_buffer_8k, start_op_cmd, uc_irq_req, uc_req} = 5'h00;
      {host_addr, host_data_in, uc_write, uc_wdata, uc_addr} = '0;
      op_mode = HBB_DISPLAY;
      {oe_q, grant_seen, load_seen, load_byte, load_addr} = '0;
      {run, last_run, err_total, comparisons} = '0;
      seed = 31750;
      srst = 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      check({host_data_oe, ready_oe, edge_irq_oe, level_interrupt_oe, ram_data_oe},
            5'h00, "reset enables");
      check({uc_pc_reset, ext_buffer_enable_n, ram_write_n, ram_read_n}, 4'hf, "reset");
      check({ready_out, edge_irq_out, level_interrupt_n_out}, 3'h0, "pin values");
      io_acc(1'b0, OFF_OPER, 8'h00, OP_RST);
      io_acc(1'b1, OFF_OPER, 8'h10, 8'h00);
      check(uc_pc_reset, 1'b1, "pc reset bit");
      io_acc(1'b0, OFF_OPER, 8'h00, 8'h10);
      io_acc(1'b1, OFF_OPER, 8'h01, 8'h00);
      check(uc_pc_reset, 1'b1, "soft reset bit");
      io_acc(1'b1, OFF_OPER, 8'h00, 8'h00);
      check(uc_pc_reset, 1'b0, "pc reset off");
      io_acc(1'b0, 4'h3, 8'h00, UNMAPPED);
      // Strobes ignored while the DMA controller owns the bus, I/O then memory address
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         host_addr <= k ? MEM_BASE : IO_BASE;
         dma_addr_enable <= 1'b1;
         io_read_strobe_n <= 1'b0;
         mem_write_strobe_n <= 1'b0;
         repeat (6) @(negedge mclk);
         check({ext_buffer_enable_n, host_data_oe, ready_oe, ram_write_n}, 4'h9, "dma");
         @(posedge mclk);
         {io_read_strobe_n, mem_write_strobe_n, dma_addr_enable} <= 3'b110;
      end
      // Mode regions: write random byte, read it back
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         @(posedge mclk);
         op_mode <= hbb_mode_t'(TBL[i][17:16]);
         printer_buffer_8k <= TBL[i][15];
         mem_acc(1'b1, TBL[i][14:1], d, 8'h00, TBL[i][0]);
         mem_acc(1'b0, TBL[i][14:1], 8'h00, TBL[i][0] ? d : UNMAPPED, TBL[i][0]);
      end
      // Microcontroller holds the RAM while the host reads
      @(posedge mclk);
      uc_req <= 1'b1;
      uc_addr <= 14'h207f;
      fork
         begin
            repeat (8) @(posedge mclk);
            uc_req <= 1'b0;
         end
      join_none
      mem_acc(1'b0, 14'h207f, 8'h00, d, 1'b1);
      check(grant_seen, 1'b1, "uc granted");
      check(uc_rdata, d, "uc read data");
      // Microcode download through memory writes
      io_acc(1'b1, OFF_OPER, 8'h06, 8'h00);
      check(ext_ucode_mode, 1'b1, "ext ucode mode");
      d = 8'($random(seed));
      mem_acc(1'b1, 14'h0123, d, 8'h00, 1'b0);
      check({load_seen, load_byte, load_addr}, {1'b1, d, 13'h0123}, "ucode load");
      io_acc(1'b1, OFF_OPER, 8'h00, 8'h00);
      // Interrupt sources per mode
      irq(1'b0, 1'b1);
      irq(1'b1, 1'b1);
      @(posedge mclk);
      op_mode <= HBB_DISPLAY;
      irq(1'b1, 1'b0);
      repeat (4) @(posedge mclk);
      check(16'(rd_q.size()), 16'h0, "reads outstanding");
      end_of_test();
   end
endmodule
